/* design/usb_ep_defines.svh */
`ifndef USB_EP_DEFINES_SVH
`define USB_EP_DEFINES_SVH
// endpoint entry in sram: 16-byte stride, bytes 0..9 used
`define ENT_LAST 4'h9
`define ENT_CTRL 4'h0
`define ENT_STAT 4'h1
`define ENT_BUF 4'h2
`define ENT_MAX 4'h4
`define ENT_CNT 4'h6
`define ENT_TOT 4'h8
`define CTRL_MP 3
`define CTRL_STALL 4
`define STAT_TGL 0
`define STAT_DONE 2
`define MAX_PAYLOAD 10'h3ff
`define WB_LAST 4'h2
`define CLK_MHZ 40
`define SUSPEND_MS 3
`define SUSPEND_CYC (`SUSPEND_MS * `CLK_MHZ * 1000)
`endif

/* design/usb_ep_pkg.sv */
package usb_ep_pkg;
  typedef enum logic [1:0] {XF_CTRL, XF_ISO, XF_BULK, XF_INT} xfer_e;
  typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} hs_e;
  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH, ST_RX, ST_TXRD, ST_TX, ST_TXEND, ST_WAITACK, ST_UPD, ST_WB, ST_DONE
  } state_e;
endpackage

/* design/usb_device_endpoint_engine.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_defines.svh"
// How it works
// - full or low speed signalling; pull-up chosen from the speed input.
// - sixteen endpoint addresses, each with an input and an output entry.
// - each entry selects control, interrupt, bulk or isochronous handling.
// - per-endpoint packet size up to 1023 bytes, ten-bit fields.
// - no local buffers; entries and data live in sram at software addresses.
// - own byte dma moves packet data to and from sram.
// - ping-pong addresses alternate both entries for one direction.
// - multipacket splits large payloads, completing only at the end.
// - completed transfers queue in a fifo, drained oldest first.
// - long idle bus allows sleep; resume raises a wake pulse.
// - engine clock select passes through, registered on the system clock.
module usb_device_endpoint_engine
  import usb_ep_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int SUSPEND_CYCLES = `SUSPEND_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic full_speed_i,
  input wire logic attach_i,
  input wire logic usb_clk_sel_i,
  input wire logic [15:0] table_base_i,
  input wire logic [15:0] pp_en_i,
  input wire logic tok_valid_i,
  input wire logic tok_in_i,
  input wire logic tok_setup_i,
  input wire logic [3:0] tok_ep_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_end_i,
  input wire logic tx_ready_i,
  input wire logic host_ack_i,
  input wire logic host_timeout_i,
  input wire logic bus_idle_i,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic cplt_pop_i,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_end_o,
  output logic tx_data1_o,
  output logic hs_valid_o,
  output logic [1:0] hs_code_o,
  output logic cplt_valid_o,
  output logic [5:0] cplt_data_o,
  output logic sleep_ok_o,
  output logic wake_o,
  output logic dp_pullup_o,
  output logic dm_pullup_o,
  output logic usb_clk_sel_o
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int SW = $clog2(SUSPEND_CYCLES + 1);

  function automatic logic [15:0] ent_addr(input logic [15:0] base, input logic [3:0] ep,
                                           input logic d, input logic [3:0] idx);
    return base + {7'h0, ep, d, 4'h0} + {12'h0, idx};
  endfunction

  function automatic logic [9:0] min10(input logic [9:0] a, input logic [9:0] b);
    return (a < b) ? a : b;
  endfunction

  state_e state_reg, state_next;
  logic [3:0] idx_reg, idx_next, ep_reg, ep_next;
  logic [7:0] ent_reg [10], ent_next [10];
  logic in_reg, in_next, setup_reg, setup_next, dsel_reg, dsel_next;
  logic [15:0] bank_reg, bank_next;
  logic [9:0] pkt_len_reg, pkt_len_next, pkt_cnt_reg, pkt_cnt_next;
  logic rx_ovf_reg, rx_ovf_next, rx_end_reg, rx_end_next, done_reg, done_next;
  logic mem_req_reg, mem_req_next, mem_we_reg, mem_we_next;
  logic [15:0] mem_addr_reg, mem_addr_next;
  logic [7:0] mem_wdata_reg, mem_wdata_next, tx_data_reg, tx_data_next;
  logic tx_valid_reg, tx_valid_next, tx_end_reg, tx_end_next, tx_data1_reg, tx_data1_next;
  logic hs_valid_reg, hs_valid_next;
  logic [1:0] hs_code_reg, hs_code_next;
  logic [5:0] fmem_reg [FIFO_DEPTH], fmem_next [FIFO_DEPTH];
  logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [PW:0] fcnt_reg, fcnt_next;
  logic cplt_valid_reg, cplt_valid_next;
  logic [5:0] cplt_data_reg, cplt_data_next;
  logic idle_s1_reg, idle_s2_reg, susp_reg, susp_next, wake_reg, wake_next;
  logic [SW-1:0] idle_cnt_reg, idle_cnt_next;
  logic dp_reg, dm_reg, clksel_reg;

  logic [9:0] maxp, cnt, tot, cnt_new;
  logic [15:0] bufa;
  logic mp, stall, push;
  xfer_e xfer;

  assign maxp = {ent_reg[5][1:0], ent_reg[4]};
  assign cnt = {ent_reg[7][1:0], ent_reg[6]};
  assign tot = {ent_reg[9][1:0], ent_reg[8]};
  assign bufa = {ent_reg[3], ent_reg[2]};
  assign xfer = xfer_e'(ent_reg[`ENT_CTRL][1:0]);
  assign mp = ent_reg[`ENT_CTRL][`CTRL_MP];
  assign stall = ent_reg[`ENT_CTRL][`CTRL_STALL] && !setup_reg;
  assign cnt_new = cnt + pkt_cnt_reg;

  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    ep_next = ep_reg;
    ent_next = ent_reg;
    in_next = in_reg;
    setup_next = setup_reg;
    dsel_next = dsel_reg;
    bank_next = bank_reg;
    pkt_len_next = pkt_len_reg;
    pkt_cnt_next = pkt_cnt_reg;
    rx_ovf_next = rx_ovf_reg;
    rx_end_next = rx_end_reg;
    done_next = done_reg;
    mem_req_next = mem_req_reg && !mem_ack_i;
    mem_we_next = mem_we_reg;
    mem_addr_next = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    tx_valid_next = tx_valid_reg && !tx_ready_i;
    tx_data_next = tx_data_reg;
    tx_end_next = 1'b0;
    tx_data1_next = tx_data1_reg;
    hs_valid_next = 1'b0;
    hs_code_next = hs_code_reg;
    push = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // tokens arriving while busy are dropped; the host retries them
        if (tok_valid_i) begin
          ep_next = tok_ep_i;
          in_next = tok_in_i;
          setup_next = tok_setup_i;
          dsel_next = pp_en_i[tok_ep_i] ? bank_reg[tok_ep_i] : tok_in_i;
          idx_next = 4'h0;
          state_next = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (!mem_req_reg) begin
          mem_req_next = 1'b1;
          mem_we_next = 1'b0;
          mem_addr_next = ent_addr(table_base_i, ep_reg, dsel_reg, idx_reg);
        end else if (mem_ack_i) begin
          ent_next[idx_reg] = mem_rdata_i;
          idx_next = idx_reg + 4'h1;
          if (idx_reg == `ENT_LAST) begin
            pkt_cnt_next = 10'h0;
            rx_ovf_next = 1'b0;
            rx_end_next = 1'b0;
            state_next = in_reg ? ST_TXRD : ST_RX;
          end
        end
      end
      ST_RX: begin
        // one byte in flight: sram must answer within a usb byte time
        if (rx_valid_i) begin
          if (stall || pkt_cnt_reg == maxp) begin
            rx_ovf_next = 1'b1;
          end else begin
            mem_req_next = 1'b1;
            mem_we_next = 1'b1;
            mem_addr_next = bufa + {6'h0, cnt} + {6'h0, pkt_cnt_reg};
            mem_wdata_next = rx_data_i;
            pkt_cnt_next = pkt_cnt_reg + 10'h1;
          end
        end
        if (rx_end_i) begin
          rx_end_next = 1'b1;
        end
        if (rx_end_reg && !mem_req_reg) begin
          if (stall) begin
            hs_valid_next = 1'b1;
            hs_code_next = HS_STALL;
            state_next = ST_IDLE;
          end else if (rx_ovf_reg) begin
            state_next = ST_IDLE;
          end else begin
            hs_valid_next = (xfer != XF_ISO);
            hs_code_next = HS_ACK;
            state_next = ST_UPD;
          end
        end
      end
      ST_TXRD: begin
        if (stall) begin
          hs_valid_next = 1'b1;
          hs_code_next = HS_STALL;
          state_next = ST_IDLE;
        end else begin
          pkt_len_next = min10(maxp, (tot > cnt) ? tot - cnt : 10'h0);
          if (pkt_len_next == pkt_cnt_reg) begin
            state_next = ST_TXEND;
          end else if (!mem_req_reg) begin
            mem_req_next = 1'b1;
            mem_we_next = 1'b0;
            mem_addr_next = bufa + {6'h0, cnt} + {6'h0, pkt_cnt_reg};
          end else if (mem_ack_i) begin
            tx_data_next = mem_rdata_i;
            tx_valid_next = 1'b1;
            pkt_cnt_next = pkt_cnt_reg + 10'h1;
            state_next = ST_TX;
          end
        end
      end
      ST_TX: begin
        if (tx_valid_reg && tx_ready_i) begin
          state_next = (pkt_cnt_reg == pkt_len_reg) ? ST_TXEND : ST_TXRD;
        end
      end
      ST_TXEND: begin
        tx_end_next = 1'b1;
        tx_data1_next = ent_reg[`ENT_STAT][`STAT_TGL];
        state_next = (xfer == XF_ISO) ? ST_UPD : ST_WAITACK;
      end
      ST_WAITACK: begin
        if (host_ack_i) begin
          state_next = ST_UPD;
        end else if (host_timeout_i) begin
          state_next = ST_IDLE;
        end
      end
      ST_UPD: begin
        done_next = !mp || pkt_cnt_reg < maxp || cnt_new >= tot;
        ent_next[`ENT_CNT] = cnt_new[7:0];
        ent_next[7] = {6'h0, cnt_new[9:8]};
        ent_next[`ENT_STAT][`STAT_DONE] = done_next;
        if (xfer != XF_ISO) begin
          ent_next[`ENT_STAT][`STAT_TGL] = !ent_reg[`ENT_STAT][`STAT_TGL];
        end
        idx_next = 4'h0;
        state_next = ST_WB;
      end
      ST_WB: begin
        // only status and count bytes go back; config stays untouched
        if (!mem_req_reg) begin
          mem_req_next = 1'b1;
          mem_we_next = 1'b1;
          mem_addr_next = ent_addr(table_base_i, ep_reg, dsel_reg,
                                   (idx_reg == 4'h0) ? `ENT_STAT : (`ENT_CNT + idx_reg - 4'h1));
          mem_wdata_next = (idx_reg == 4'h0) ? ent_reg[`ENT_STAT] : ent_reg[`ENT_CNT + idx_reg - 4'h1];
        end else if (mem_ack_i) begin
          idx_next = idx_reg + 4'h1;
          state_next = (idx_reg == `WB_LAST) ? ST_DONE : ST_WB;
        end
      end
      ST_DONE: begin
        if (!done_reg) begin
          state_next = ST_IDLE;
        end else if (fcnt_reg != (PW+1)'(FIFO_DEPTH)) begin
          push = 1'b1;
          if (pp_en_i[ep_reg]) begin
            bank_next[ep_reg] = !bank_reg[ep_reg];
          end
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_comb begin
    fmem_next = fmem_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    fcnt_next = fcnt_reg;
    if (push) begin
      fmem_next[wp_reg] = {ep_reg, in_reg, dsel_reg};
      wp_next = wp_reg + PW'(1);
      fcnt_next = fcnt_next + (PW+1)'(1);
    end
    if (cplt_pop_i && fcnt_reg != '0) begin
      rp_next = rp_reg + PW'(1);
      fcnt_next = fcnt_next - (PW+1)'(1);
    end
    cplt_valid_next = (fcnt_next != '0);
    cplt_data_next = cplt_valid_next ? fmem_next[rp_next] : 6'h00;
  end

  always_comb begin
    idle_cnt_next = idle_s2_reg ? idle_cnt_reg : '0;
    susp_next = susp_reg;
    wake_next = 1'b0;
    if (idle_s2_reg && !susp_reg) begin
      idle_cnt_next = idle_cnt_reg + SW'(1);
      if (idle_cnt_reg == SW'(SUSPEND_CYCLES - 1)) begin
        susp_next = 1'b1;
      end
    end
    if (!idle_s2_reg && susp_reg) begin
      susp_next = 1'b0;
      wake_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
      idx_reg <= 4'h0;
      ep_reg <= 4'h0;
      ent_reg <= '{default: 8'h00};
      in_reg <= 1'b0;
      setup_reg <= 1'b0;
      dsel_reg <= 1'b0;
      bank_reg <= 16'h0000;
      pkt_len_reg <= 10'h0;
      pkt_cnt_reg <= 10'h0;
      rx_ovf_reg <= 1'b0;
      rx_end_reg <= 1'b0;
      done_reg <= 1'b0;
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= 16'h0000;
      mem_wdata_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      tx_end_reg <= 1'b0;
      tx_data1_reg <= 1'b0;
      hs_valid_reg <= 1'b0;
      hs_code_reg <= 2'h0;
      fmem_reg <= '{default: 6'h00};
      wp_reg <= '0;
      rp_reg <= '0;
      fcnt_reg <= '0;
      cplt_valid_reg <= 1'b0;
      cplt_data_reg <= 6'h00;
      idle_s1_reg <= 1'b0;
      idle_s2_reg <= 1'b0;
      idle_cnt_reg <= '0;
      susp_reg <= 1'b0;
      wake_reg <= 1'b0;
      dp_reg <= 1'b0;
      dm_reg <= 1'b0;
      clksel_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      ep_reg <= ep_next;
      ent_reg <= ent_next;
      in_reg <= in_next;
      setup_reg <= setup_next;
      dsel_reg <= dsel_next;
      bank_reg <= bank_next;
      pkt_len_reg <= pkt_len_next;
      pkt_cnt_reg <= pkt_cnt_next;
      rx_ovf_reg <= rx_ovf_next;
      rx_end_reg <= rx_end_next;
      done_reg <= done_next;
      mem_req_reg <= mem_req_next;
      mem_we_reg <= mem_we_next;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      tx_valid_reg <= tx_valid_next;
      tx_data_reg <= tx_data_next;
      tx_end_reg <= tx_end_next;
      tx_data1_reg <= tx_data1_next;
      hs_valid_reg <= hs_valid_next;
      hs_code_reg <= hs_code_next;
      fmem_reg <= fmem_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      fcnt_reg <= fcnt_next;
      cplt_valid_reg <= cplt_valid_next;
      cplt_data_reg <= cplt_data_next;
      idle_s1_reg <= bus_idle_i;
      idle_s2_reg <= idle_s1_reg;
      idle_cnt_reg <= idle_cnt_next;
      susp_reg <= susp_next;
      wake_reg <= wake_next;
      dp_reg <= attach_i && full_speed_i;
      dm_reg <= attach_i && !full_speed_i;
      clksel_reg <= usb_clk_sel_i;
    end
  end

  assign mem_req_o = mem_req_reg;
  assign mem_we_o = mem_we_reg;
  assign mem_addr_o = mem_addr_reg;
  assign mem_wdata_o = mem_wdata_reg;
  assign tx_valid_o = tx_valid_reg;
  assign tx_data_o = tx_data_reg;
  assign tx_end_o = tx_end_reg;
  assign tx_data1_o = tx_data1_reg;
  assign hs_valid_o = hs_valid_reg;
  assign hs_code_o = hs_code_reg;
  assign cplt_valid_o = cplt_valid_reg;
  assign cplt_data_o = cplt_data_reg;
  assign sleep_ok_o = susp_reg;
  assign wake_o = wake_reg;
  assign dp_pullup_o = dp_reg;
  assign dm_pullup_o = dm_reg;
  assign usb_clk_sel_o = clksel_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_tok_taken;
    state_reg == ST_IDLE && tok_valid_i;
  endsequence
  sequence s_fetch_first;
    mem_req_o && !mem_we_o && mem_addr_o == ent_addr(table_base_i, ep_reg, dsel_reg, 4'h0);
  endsequence
  chk_fetch_before_use: assert property (s_tok_taken |=> ##1 s_fetch_first)
    else $error("entry fetch did not start after token");
  chk_packet_size: assert property (tx_valid_o |-> pkt_cnt_reg <= pkt_len_reg && pkt_len_reg <= maxp)
    else $error("transmit byte beyond packet size");
  chk_push_visible: assert property (push && fcnt_reg == '0 |=> cplt_valid_o && cplt_data_o == $past(fmem_next[wp_reg]))
    else $error("completion entry not presented");
  chk_no_early_push: assert property (state_reg == ST_DONE && !done_reg |=> $stable(fcnt_reg) || $past(cplt_pop_i))
    else $error("unfinished multipacket transfer queued");
  chk_pingpong_flip: assert property (push && pp_en_i[ep_reg] |=> bank_reg[$past(ep_reg)] != $past(bank_reg[ep_reg]))
    else $error("ping-pong bank did not alternate");
  chk_rx_dma_write: assert property (state_reg == ST_RX && rx_valid_i && !stall && pkt_cnt_reg != maxp
                                     |=> mem_req_o && mem_we_o && mem_wdata_o == $past(rx_data_i))
    else $error("received byte not written to sram");
  chk_wake_resume: assert property (susp_reg && !idle_s2_reg |=> wake_o ##1 !wake_o && !sleep_ok_o)
    else $error("resume did not wake system");
  chk_pullup_speed: assert property (attach_i && !full_speed_i |=> dm_pullup_o && !dp_pullup_o)
    else $error("pull-up does not match speed");
  chk_clk_select: assert property (##1 usb_clk_sel_o == $past(usb_clk_sel_i))
    else $error("clock select not passed through");
endmodule
`default_nettype wire

/* sim/sram_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_model #(
  parameter int LAT = 2
) (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic ack_o,
  output logic [7:0] rdata_o
);
  // entries and buffers live here, placed by the bench
  logic [7:0] mem [0:4095];
  int wait_cnt;
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    wait_cnt = 0;
    ack_o = 1'b0;
    rdata_o = 8'h00;
  end
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    // outside an answer the data lines invert every cycle instead of holding the last value
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o) begin
      if (wait_cnt >= LAT) begin
        wait_cnt <= 0;
        ack_o <= 1'b1;
        if (we_i) mem[addr_i[11:0]] <= wdata_i;
        else rdata_o <= mem[addr_i[11:0]];
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/tb_usb_device_endpoint_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_usb_device_endpoint_engine;
  import usb_ep_pkg::*;
  logic clk_i, resetn_i, full_speed_i, attach_i, usb_clk_sel_i, tok_valid_i, tok_in_i, tok_setup_i;
  logic rx_valid_i, rx_end_i, tx_ready_i, host_ack_i, host_timeout_i, bus_idle_i, mem_ack_i, cplt_pop_i;
  logic [15:0] table_base_i, pp_en_i, mem_addr_o;
  logic [3:0] tok_ep_i;
  logic [7:0] rx_data_i, mem_rdata_i, mem_wdata_o, tx_data_o;
  logic mem_req_o, mem_we_o, tx_valid_o, tx_end_o, tx_data1_o, hs_valid_o, cplt_valid_o;
  logic sleep_ok_o, wake_o, dp_pullup_o, dm_pullup_o, usb_clk_sel_o;
  logic [1:0] hs_code_o, last_hs;
  logic [5:0] cplt_data_o;
  logic last_tgl;
  logic [7:0] txq [$];
  int mismatches = 0, cmp_count = 0, cycles = 0, acks = 0, hs_cnt = 0, tx_ends = 0, wakes = 0;

  usb_device_endpoint_engine #(.FIFO_DEPTH(8), .SUSPEND_CYCLES(20)) usb_device_endpoint_engine_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .full_speed_i(full_speed_i), .attach_i(attach_i),
    .usb_clk_sel_i(usb_clk_sel_i), .table_base_i(table_base_i), .pp_en_i(pp_en_i),
    .tok_valid_i(tok_valid_i), .tok_in_i(tok_in_i), .tok_setup_i(tok_setup_i), .tok_ep_i(tok_ep_i),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_end_i(rx_end_i), .tx_ready_i(tx_ready_i),
    .host_ack_i(host_ack_i), .host_timeout_i(host_timeout_i), .bus_idle_i(bus_idle_i),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .cplt_pop_i(cplt_pop_i),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_end_o(tx_end_o), .tx_data1_o(tx_data1_o),
    .hs_valid_o(hs_valid_o), .hs_code_o(hs_code_o), .cplt_valid_o(cplt_valid_o),
    .cplt_data_o(cplt_data_o), .sleep_ok_o(sleep_ok_o), .wake_o(wake_o), .dp_pullup_o(dp_pullup_o),
    .dm_pullup_o(dm_pullup_o), .usb_clk_sel_o(usb_clk_sel_o));

  sram_model #(.LAT(2)) sram_model_inst (.clk_i(clk_i), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  always #12.5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cycles++;
    if (mem_req_o && mem_ack_i) acks++;
    if (tx_valid_o && tx_ready_i) txq.push_back(tx_data_o);
    if (tx_end_o) begin
      tx_ends++;
      last_tgl = tx_data1_o;
    end
    if (hs_valid_o) begin
      hs_cnt++;
      last_hs = hs_code_o;
    end
    if (wake_o) wakes++;
    // generous ceiling: the whole sequence needs well under 2000 cycles
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report();
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(string name, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_acks(int n);
    int goal;
    goal = acks + n;
    while (acks < goal) @(negedge clk_i);
  endtask

  function automatic int ent(int ep, int sel);
    return 16'h0100 + ep * 32 + sel * 16;
  endfunction

  task automatic set_ent(int a, logic [7:0] ctrl, logic [15:0] bufa, logic [9:0] mx, logic [9:0] tot);
    logic [7:0] b [10];
    b = '{ctrl, 8'h00, bufa[7:0], bufa[15:8], mx[7:0], {6'h00, mx[9:8]}, 8'h00, 8'h00, tot[7:0],
          {6'h00, tot[9:8]}};
    for (int i = 0; i < 10; i++) sram_model_inst.mem[a + i] = b[i];
  endtask

  task automatic token(logic [3:0] ep, logic dir_in);
    tok_ep_i = ep;
    tok_in_i = dir_in;
    tok_valid_i = 1'b1;
    @(negedge clk_i);
    tok_valid_i = 1'b0;
    wait_acks(10);
  endtask

  task automatic rx_pkt(int n, logic [7:0] first);
    for (int i = 0; i < n; i++) begin
      rx_data_i = first + 8'(i);
      rx_valid_i = 1'b1;
      @(negedge clk_i);
      rx_valid_i = 1'b0;
      wait_acks(1);
    end
    rx_end_i = 1'b1;
    @(negedge clk_i);
    rx_end_i = 1'b0;
  endtask

  task automatic t_reset_pins();
    cmp("mem_req", 1'b0, mem_req_o);
    cmp("dp_pullup", 1'b1, dp_pullup_o);
    cmp("dm_pullup", 1'b0, dm_pullup_o);
    full_speed_i = 1'b0;
    usb_clk_sel_i = 1'b1;
    repeat (2) @(negedge clk_i);
    cmp("dm_pullup", 1'b1, dm_pullup_o);
    cmp("clk_sel", 1'b1, usb_clk_sel_o);
    full_speed_i = 1'b1;
  endtask

  task automatic t_out(int ep, int sel, logic [7:0] ctrl, logic [15:0] bufa, int n, logic [7:0] d);
    int h;
    h = hs_cnt;
    set_ent(ent(ep, sel), ctrl, bufa, 10'h008, 10'h008);
    token(4'(ep), 1'b0);
    rx_pkt(n, d);
    wait_acks(3);
    repeat (4) @(negedge clk_i);
    for (int i = 0; i < n; i++) cmp("out_byte", d + 8'(i), sram_model_inst.mem[bufa + i]);
    cmp("entry_count", 8'(n), sram_model_inst.mem[ent(ep, sel) + 6]);
    cmp("entry_done", 1'b1, sram_model_inst.mem[ent(ep, sel) + 1][2]);
    cmp("hs_count", (ctrl[1:0] == 2'h1) ? h : h + 1, hs_cnt);
    if (ctrl[1:0] != 2'h1) cmp("hs_code", HS_ACK, last_hs);
  endtask

  task automatic t_in_multi();
    set_ent(ent(2, 1), 8'h0a, 16'h0a00, 10'h002, 10'h003);
    sram_model_inst.mem[16'h0a00] = 8'h11;
    sram_model_inst.mem[16'h0a01] = 8'h22;
    sram_model_inst.mem[16'h0a02] = 8'h33;
    // first packet gets no host answer, so it must come again unchanged
    for (int p = 0; p < 3; p++) begin
      txq.delete();
      if (p == 2) tx_ready_i = 1'b0;
      token(4'h2, 1'b1);
      if (p == 2) begin
        repeat (8) @(negedge clk_i);
        cmp("tx_hold_valid", 1'b1, tx_valid_o);
        cmp("tx_hold_data", 8'h33, tx_data_o);
        tx_ready_i = 1'b1;
      end
      while (tx_ends == p) @(negedge clk_i);
      cmp("in_len", (p == 2) ? 1 : 2, txq.size());
      cmp("in_byte", (p == 2) ? 8'h33 : 8'h11, txq[0]);
      if (p < 2) cmp("in_byte2", 8'h22, txq[1]);
      cmp("in_toggle", p == 2, last_tgl);
      if (p == 0) host_timeout_i = 1'b1;
      else host_ack_i = 1'b1;
      @(negedge clk_i);
      host_timeout_i = 1'b0;
      host_ack_i = 1'b0;
      if (p > 0) wait_acks(3);
      repeat (4) @(negedge clk_i);
      if (p == 0) cmp("in_retry_count", 8'h00, sram_model_inst.mem[ent(2, 1) + 6]);
    end
    cmp("in_count", 8'h03, sram_model_inst.mem[ent(2, 1) + 6]);
  endtask

  task automatic t_fifo_order();
    logic [5:0] exp [6];
    exp = '{6'h0c, 6'h04, 6'h14, 6'h15, 6'h0b, 6'h00};
    for (int i = 0; i < 5; i++) begin
      cmp("cplt_valid", 1'b1, cplt_valid_o);
      cmp("cplt_data", exp[i], cplt_data_o);
      cplt_pop_i = 1'b1;
      @(negedge clk_i);
      cplt_pop_i = 1'b0;
      @(negedge clk_i);
    end
    cmp("cplt_empty", 1'b0, cplt_valid_o);
  endtask

  task automatic t_stall();
    int h;
    h = hs_cnt;
    set_ent(ent(15, 0), 8'h12, 16'h0b00, 10'h3ff, 10'h3ff);
    token(4'hf, 1'b0);
    // a stalled endpoint writes nothing, so no sram answer is awaited here
    rx_data_i = 8'h5a;
    rx_valid_i = 1'b1;
    @(negedge clk_i);
    rx_valid_i = 1'b0;
    rx_end_i = 1'b1;
    @(negedge clk_i);
    rx_end_i = 1'b0;
    while (hs_cnt == h) @(negedge clk_i);
    cmp("stall_code", HS_STALL, last_hs);
    repeat (40) @(negedge clk_i);
    cmp("stall_nowrite", 8'h00, sram_model_inst.mem[16'h0b00]);
    h = hs_cnt;
    set_ent(ent(15, 0), 8'h10, 16'h0b00, 10'h3ff, 10'h3ff);
    tok_setup_i = 1'b1;
    token(4'hf, 1'b0);
    tok_setup_i = 1'b0;
    rx_pkt(1, 8'h5b);
    while (hs_cnt == h) @(negedge clk_i);
    cmp("setup_code", HS_ACK, last_hs);
    wait_acks(3);
    repeat (4) @(negedge clk_i);
    cmp("setup_byte", 8'h5b, sram_model_inst.mem[16'h0b00]);
    cmp("setup_cplt", 6'h3c, cplt_data_o);
  endtask

  task automatic t_suspend();
    bus_idle_i = 1'b1;
    repeat (10) @(negedge clk_i);
    cmp("sleep_early", 1'b0, sleep_ok_o);
    repeat (20) @(negedge clk_i);
    cmp("sleep_ok", 1'b1, sleep_ok_o);
    bus_idle_i = 1'b0;
    repeat (6) @(negedge clk_i);
    cmp("wake_pulses", 1, wakes);
    cmp("sleep_drop", 1'b0, sleep_ok_o);
  endtask

  initial begin
    {clk_i, resetn_i, usb_clk_sel_i, tok_valid_i, tok_in_i, tok_setup_i, rx_valid_i, rx_end_i} = '0;
    {host_ack_i, host_timeout_i, bus_idle_i, cplt_pop_i, tok_ep_i, rx_data_i} = '0;
    {full_speed_i, attach_i, tx_ready_i} = 3'h7;
    table_base_i = 16'h0100;
    pp_en_i = 16'h0020;
    repeat (6) @(negedge clk_i);
    resetn_i = 1'b1;
    @(negedge clk_i);
    t_reset_pins();
    t_out(3, 0, 8'h03, 16'h0800, 3, 8'ha0);
    t_out(1, 0, 8'h01, 16'h0840, 2, 8'hc0);
    t_out(5, 0, 8'h02, 16'h0900, 1, 8'h70);
    t_out(5, 1, 8'h02, 16'h0910, 1, 8'h80);
    t_in_multi();
    t_fifo_order();
    t_stall();
    t_suspend();
    final_report();
  end
endmodule
`default_nettype wire
